// *** design/corner_interp.v ***
// two-point linear interpolation of a corner dac code
`include "rf_cal_consts.vh"
module corner_interp (
    input wire [`DAC_W-1:0] code_a,
    input wire [`FREQ_W-1:0] freq_a,
    input wire [`DAC_W-1:0] code_b,
    input wire [`FREQ_W-1:0] freq_b,
    input wire [`FREQ_W-1:0] target,
    output wire [`DAC_W-1:0] code_new
);
    // combinational divide: fine at cal rate, long path is accepted
    wire signed [33:0] df;
    wire signed [33:0] dt;
    wire signed [13:0] dc;
    wire signed [47:0] prod;
    wire signed [47:0] quot;
    wire signed [47:0] res;
    assign df = $signed({2'b00, freq_b}) - $signed({2'b00, freq_a});
    assign dt = $signed({2'b00, target}) - $signed({2'b00, freq_a});
    assign dc = $signed({2'b00, code_b}) - $signed({2'b00, code_a});
    assign prod = dt * dc;
    // equal frequencies give no slope: keep the stored code
    assign quot = (df == 34'sd0) ? 48'sd0 : prod / df;
    assign res = quot + $signed({36'd0, code_a});
    assign code_new = (res < 48'sd0) ? {`DAC_W{1'b0}} :
        (res > 48'sd4095) ? {`DAC_W{1'b1}} : res[`DAC_W-1:0];
endmodule // corner_interp

// *** design/rf_cal_consts.vh ***
// constants for the rf ramp frequency calibration sequencer
`ifndef RF_CAL_CONSTS_VH
`define RF_CAL_CONSTS_VH
// frequencies in kHz, measurement unit reports kHz
`define LOW_TARGET_KHZ 32'd24025000
`define HIGH_TARGET_KHZ 32'd24225000
`define DRIFT_KHZ 32'd5000
`define LOW_MIN_KHZ 32'd24020000
`define LOW_MAX_KHZ 32'd24030000
`define HIGH_MIN_KHZ 32'd24220000
`define HIGH_MAX_KHZ 32'd24230000
`define DAC_W 12
`define FREQ_W 32
`define STEP_DEFAULT 12'h004
`define PROBE_DEFAULT 12'h010
`define DAC_RESET 12'h800
`endif

// *** design/rf_ramp_frequency_calibration.v ***
// calibration sequencer mapping tuning dac codes to rf corner frequencies
`include "rf_cal_consts.vh"
// Functional notes
// - transmit path stays off during every check and calibration run
// - all frequency checks come from the divider output measurement
// - radar measurement enables transmit, disables divider, applies shift offset
// - default corners 24.025 and 24.225 GHz, each may drift 5 MHz
// - boot enables chip, transmit off, reads temperature voltage into dac
// - lower dac code means lower frequency, higher code higher frequency
// - boot steps code down until frequency below 24.030 GHz
// - boot then steps up until frequency above 24.220 GHz
// - boot ends with one full recalibration of both corners
// - after last chirp, transmit off, check lower corner window
// - lower fail recalibrates now, else check upper window
// - any failure recalibrates both corners to keep 200 MHz span
// - upper-only failure recalibrates upper first, then lower
// - after recalibration dac goes to mean of both corner codes
// - intermediate code higher if corner read low, lower if high
// - new corner code by linear proportion of two measured points
module rf_ramp_frequency_calibration (
    input wire clk,
    input wire srst,
    input wire boot_start,
    input wire frame_done,
    input wire measure_start,
    input wire [`DAC_W-1:0] step_size,
    input wire [`DAC_W-1:0] probe_offset,
    input wire signed [`DAC_W-1:0] tx_shift,
    input wire [`DAC_W-1:0] chirp_code,
    input wire adc_done,
    input wire [`DAC_W-1:0] temp_proportional_voltage,
    input wire meas_valid,
    input wire [`FREQ_W-1:0] meas_freq,
    output reg chip_enable,
    output reg tx_enable,
    output reg divider_enable,
    output wire adc_request,
    output wire meas_request,
    output reg [`DAC_W-1:0] dac_code,
    output reg [`DAC_W-1:0] low_code,
    output reg [`DAC_W-1:0] high_code,
    output reg cal_busy,
    output reg cal_done,
    output reg recal_event,
    output reg radar_active
);
    // one-hot sequencer states
    localparam [11:0] S_IDLE = 12'h001;
    localparam [11:0] S_ADC = 12'h002;
    localparam [11:0] S_MEAS = 12'h004;
    localparam [11:0] S_DOWN = 12'h008;
    localparam [11:0] S_UP = 12'h010;
    localparam [11:0] S_CHK_LO = 12'h020;
    localparam [11:0] S_CHK_HI = 12'h040;
    localparam [11:0] S_REF = 12'h080;
    localparam [11:0] S_PROBE = 12'h100;
    localparam [11:0] S_SOLVE = 12'h200;
    localparam [11:0] S_MID = 12'h400;
    localparam [11:0] S_RADAR = 12'h800;
    // what a finished measurement is used for
    localparam [2:0] U_DOWN = 3'd0;
    localparam [2:0] U_UP = 3'd1;
    localparam [2:0] U_CHKLO = 3'd2;
    localparam [2:0] U_CHKHI = 3'd3;
    localparam [2:0] U_REF = 3'd4;
    localparam [2:0] U_PROBE = 3'd5;

    // sequencer and corner-solver working registers
    reg [11:0] state;
    reg [2:0] use_of;
    reg req_pend;
    reg adc_pend;
    reg cur_high;
    reg second;
    reg high_first;
    reg [`FREQ_W-1:0] ref_freq;
    reg [`FREQ_W-1:0] probe_freq;
    reg [`DAC_W-1:0] probe_code;
    wire [`DAC_W-1:0] cur_code;
    wire [`FREQ_W-1:0] cur_target;
    wire [`DAC_W-1:0] solved;

    // saturating add and subtract on dac codes
    function [`DAC_W-1:0] sat_add;
        input [`DAC_W-1:0] a;
        input [`DAC_W-1:0] b;
        reg [`DAC_W:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            sat_add = s[`DAC_W] ? {`DAC_W{1'b1}} : s[`DAC_W-1:0];
        end
    endfunction
    function [`DAC_W-1:0] sat_sub;
        input [`DAC_W-1:0] a;
        input [`DAC_W-1:0] b;
        begin
            sat_sub = (a > b) ? a - b : {`DAC_W{1'b0}};
        end
    endfunction
    function in_window;
        input [`FREQ_W-1:0] f;
        input [`FREQ_W-1:0] lo;
        input [`FREQ_W-1:0] hi;
        begin
            in_window = (f >= lo) && (f <= hi);
        end
    endfunction

    assign cur_code = cur_high ? high_code : low_code;
    assign cur_target = cur_high ? `HIGH_TARGET_KHZ : `LOW_TARGET_KHZ;
    // strobes are one-cycle pulses from pending flags
    assign meas_request = req_pend;
    assign adc_request = adc_pend;

    // solver always sees the reference and probe points of this corner
    corner_interp u_interp (
        .code_a(cur_code),
        .freq_a(ref_freq),
        .code_b(probe_code),
        .freq_b(probe_freq),
        .target(cur_target),
        .code_new(solved)
    );

    // main sequencer
    always @(posedge clk) begin
        if (srst) begin
            state <= S_IDLE;
            use_of <= U_DOWN;
            req_pend <= 1'b0;
            adc_pend <= 1'b0;
            cur_high <= 1'b0;
            second <= 1'b0;
            high_first <= 1'b0;
            ref_freq <= {`FREQ_W{1'b0}};
            probe_freq <= {`FREQ_W{1'b0}};
            probe_code <= {`DAC_W{1'b0}};
            chip_enable <= 1'b0;
            tx_enable <= 1'b0;
            divider_enable <= 1'b0;
            dac_code <= `DAC_RESET;
            low_code <= `DAC_RESET;
            high_code <= `DAC_RESET;
            cal_busy <= 1'b0;
            cal_done <= 1'b0;
            recal_event <= 1'b0;
            radar_active <= 1'b0;
        end else begin
            req_pend <= 1'b0;
            adc_pend <= 1'b0;
            recal_event <= 1'b0;
            case (state)
            S_IDLE: begin
                tx_enable <= 1'b0;
                // a boot request wins over a radar start
                if (boot_start) begin
                    chip_enable <= 1'b1;
                    tx_enable <= 1'b0;
                    divider_enable <= 1'b1;
                    cal_busy <= 1'b1;
                    cal_done <= 1'b0;
                    adc_pend <= 1'b1;
                    state <= S_ADC;
                end else if (cal_done && measure_start) begin
                    state <= S_RADAR;
                end
            end
            S_ADC: begin
                if (adc_done) begin
                    dac_code <= temp_proportional_voltage;
                    low_code <= temp_proportional_voltage;
                    use_of <= U_DOWN;
                    req_pend <= 1'b1;
                    state <= S_MEAS;
                end
            end
            S_MEAS: begin
                // no dac update until the result arrives
                if (meas_valid) begin
                    case (use_of)
                    U_DOWN: state <= S_DOWN;
                    U_UP: state <= S_UP;
                    U_CHKLO: state <= S_CHK_LO;
                    U_CHKHI: state <= S_CHK_HI;
                    U_REF: state <= S_REF;
                    default: state <= S_PROBE;
                    endcase
                    probe_freq <= meas_freq;
                end
            end
            S_DOWN: begin
                // a code pinned at zero keeps stepping; callers must time out
                if (probe_freq < `LOW_MAX_KHZ) begin
                    low_code <= dac_code;
                    dac_code <= sat_add(dac_code, step_size);
                    use_of <= U_UP;
                end else begin
                    dac_code <= sat_sub(dac_code, step_size);
                end
                req_pend <= 1'b1;
                state <= S_MEAS;
            end
            S_UP: begin
                if (probe_freq > `HIGH_MIN_KHZ) begin
                    high_code <= dac_code;
                    // full recalibration closes the boot run
                    high_first <= 1'b0;
                    cur_high <= 1'b0;
                    second <= 1'b0;
                    dac_code <= low_code;
                    use_of <= U_REF;
                    recal_event <= 1'b1;
                end else begin
                    dac_code <= sat_add(dac_code, step_size);
                end
                req_pend <= 1'b1;
                state <= S_MEAS;
            end
            S_CHK_LO: begin
                if (!in_window(probe_freq, `LOW_MIN_KHZ, `LOW_MAX_KHZ)) begin
                    // lower first, then upper
                    high_first <= 1'b0;
                    cur_high <= 1'b0;
                    second <= 1'b0;
                    // failing check doubles as the reference point
                    ref_freq <= probe_freq;
                    recal_event <= 1'b1;
                    dac_code <= probe_freq < `LOW_MIN_KHZ ?
                        sat_add(low_code, probe_offset) :
                        sat_sub(low_code, probe_offset);
                    probe_code <= probe_freq < `LOW_MIN_KHZ ?
                        sat_add(low_code, probe_offset) :
                        sat_sub(low_code, probe_offset);
                    use_of <= U_PROBE;
                    req_pend <= 1'b1;
                    state <= S_MEAS;
                end else begin
                    dac_code <= high_code;
                    use_of <= U_CHKHI;
                    req_pend <= 1'b1;
                    state <= S_MEAS;
                end
            end
            S_CHK_HI: begin
                if (!in_window(probe_freq, `HIGH_MIN_KHZ, `HIGH_MAX_KHZ)) begin
                    // upper-only failure: solve the upper corner first
                    high_first <= 1'b1;
                    cur_high <= 1'b1;
                    second <= 1'b0;
                    recal_event <= 1'b1;
                    state <= S_REF;
                end else begin
                    state <= S_MID;
                end
            end
            S_REF: begin
                // reference point at the stored code, then probe
                ref_freq <= probe_freq;
                if ((cur_high && probe_freq < `HIGH_MIN_KHZ) ||
                    (!cur_high && probe_freq < `LOW_MIN_KHZ)) begin
                    probe_code <= sat_add(cur_code, probe_offset);
                    dac_code <= sat_add(cur_code, probe_offset);
                end else begin
                    probe_code <= sat_sub(cur_code, probe_offset);
                    dac_code <= sat_sub(cur_code, probe_offset);
                end
                use_of <= U_PROBE;
                req_pend <= 1'b1;
                state <= S_MEAS;
            end
            S_PROBE: begin
                // one cycle for the probe result to reach the solver
                state <= S_SOLVE;
            end
            S_SOLVE: begin
                if (cur_high) begin
                    high_code <= solved;
                end else begin
                    low_code <= solved;
                end
                if (second) begin
                    state <= S_MID;
                end else begin
                    // other corner always follows
                    second <= 1'b1;
                    cur_high <= ~high_first;
                    dac_code <= high_first ? low_code : high_code;
                    use_of <= U_REF;
                    req_pend <= 1'b1;
                    state <= S_MEAS;
                end
            end
            S_MID: begin
                dac_code <= mean_code(low_code, high_code);
                cal_busy <= 1'b0;
                cal_done <= 1'b1;
                tx_enable <= 1'b0;
                state <= S_IDLE;
            end
            S_RADAR: begin
                radar_active <= 1'b1;
                tx_enable <= 1'b1;
                divider_enable <= 1'b0;
                // chirp code corrected for the pull of the transmit load
                dac_code <= shift_code(chirp_code, tx_shift);
                if (frame_done) begin
                    radar_active <= 1'b0;
                    tx_enable <= 1'b0;
                    divider_enable <= 1'b1;
                    cal_busy <= 1'b1;
                    dac_code <= low_code;
                    use_of <= U_CHKLO;
                    req_pend <= 1'b1;
                    state <= S_MEAS;
                end
            end
            default: state <= S_IDLE;
            endcase
        end
    end

    // midpoint rounds down, so it never leaves the dac range
    function [`DAC_W-1:0] mean_code;
        input [`DAC_W-1:0] a;
        input [`DAC_W-1:0] b;
        reg [`DAC_W:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            mean_code = s[`DAC_W:1];
        end
    endfunction
    // offset for the transmit-on shift, clamped to the dac range
    function [`DAC_W-1:0] shift_code;
        input [`DAC_W-1:0] c;
        input signed [`DAC_W-1:0] d;
        reg signed [`DAC_W+1:0] s;
        begin
            s = $signed({2'b00, c}) + {{2{d[`DAC_W-1]}}, d};
            shift_code = s[`DAC_W+1] ? {`DAC_W{1'b0}} :
                (s[`DAC_W] ? {`DAC_W{1'b1}} : s[`DAC_W-1:0]);
        end
    endfunction
endmodule // rf_ramp_frequency_calibration

// *** verification/rf_cal_chk.sv ***
// assertion checker for the rf calibration sequencer ports
`include "rf_cal_consts.vh"
module rf_cal_chk (
    input wire clk,
    input wire srst,
    input wire frame_done,
    input wire adc_done,
    input wire [`DAC_W-1:0] temp_proportional_voltage,
    input wire meas_valid,
    input wire [`DAC_W-1:0] chirp_code,
    input wire signed [`DAC_W-1:0] tx_shift,
    input wire chip_enable,
    input wire tx_enable,
    input wire divider_enable,
    input wire adc_request,
    input wire meas_request,
    input wire [`DAC_W-1:0] dac_code,
    input wire [`DAC_W-1:0] low_code,
    input wire [`DAC_W-1:0] high_code,
    input wire cal_busy,
    input wire cal_done,
    input wire radar_active
);
    timeunit 1ns;
    timeprecision 1ps;
    reg pending;
    reg adc_wait;
    wire [`DAC_W:0] sum = {1'b0, low_code} + {1'b0, high_code};
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // outstanding request trackers, cleared only by the answer
    always @(posedge clk) begin
        if (srst) begin
            pending <= 1'b0;
            adc_wait <= 1'b0;
        end else begin
            pending <= meas_request | (pending & ~meas_valid);
            adc_wait <= adc_request | (adc_wait & ~adc_done);
        end
    end
    a_tx_off_busy: assert property (cal_busy |-> !tx_enable)
        else $error("transmit on during calibration");
    a_req_divider: assert property (meas_request |-> divider_enable
        && !tx_enable) else $error("measure without divider");
    a_radar_path: assert property (radar_active |-> tx_enable
        && !divider_enable) else $error("radar path wrong");
    a_radar_shift: assert property (radar_active && $past(radar_active)
        |-> dac_code == $past(chirp_code) + $past(tx_shift))
        else $error("radar dac offset wrong");
    a_boot_enable: assert property ($rose(chip_enable) |-> adc_request
        && !tx_enable) else $error("boot enable wrong");
    a_temp_to_dac: assert property (adc_wait && adc_done |=> dac_code
        == $past(temp_proportional_voltage))
        else $error("temperature not applied");
    a_mid_code: assert property ($fell(cal_busy) |-> dac_code
        == sum[`DAC_W:1]) else $error("mid code wrong");
    a_frame_low: assert property (radar_active && frame_done |=>
        !tx_enable && divider_enable && dac_code == low_code)
        else $error("frame check start wrong");
    a_req_single: assert property (meas_request |-> !pending)
        else $error("second measurement in flight");
    a_dac_hold: assert property (pending |-> $stable(dac_code))
        else $error("dac moved during measurement");
    c_boot: cover property ($rose(cal_done));
    c_frame: cover property (radar_active && frame_done);
    c_recal: cover property (meas_request && cal_busy);
endmodule // rf_cal_chk

bind rf_ramp_frequency_calibration rf_cal_chk i_chk (
    .clk(clk), .srst(srst), .frame_done(frame_done), .adc_done(adc_done),
    .temp_proportional_voltage(temp_proportional_voltage),
    .meas_valid(meas_valid), .chirp_code(chirp_code), .tx_shift(tx_shift),
    .chip_enable(chip_enable), .tx_enable(tx_enable),
    .divider_enable(divider_enable), .adc_request(adc_request),
    .meas_request(meas_request), .dac_code(dac_code),
    .low_code(low_code), .high_code(high_code), .cal_busy(cal_busy),
    .cal_done(cal_done), .radar_active(radar_active)
);

// *** verification/tb.sv ***
// self-checking bench for the rf calibration sequencer
`include "rf_cal_consts.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, srst, boot_start, frame_done, measure_start;
    logic [`DAC_W-1:0] step_size, probe_offset, chirp_code;
    logic signed [`DAC_W-1:0] tx_shift;
    logic [`FREQ_W-1:0] f_base, f_slope;
    wire adc_done, meas_valid, chip_enable, tx_enable, divider_enable;
    wire adc_request, meas_request, cal_busy, cal_done, recal_event;
    wire radar_active;
    wire [`DAC_W-1:0] dac_code, low_code, high_code, temp;
    wire [`FREQ_W-1:0] meas_freq;
    logic [`DAC_W-1:0] seq[$];
    int error_cnt, checked, rc, cycles;
    xcvr_model i_model (.clk(clk), .srst(srst), .chip_enable(chip_enable),
        .tx_enable(tx_enable), .divider_enable(divider_enable),
        .adc_request(adc_request), .meas_request(meas_request),
        .dac_code(dac_code), .f_base(f_base), .f_slope(f_slope),
        .adc_done(adc_done), .temp_proportional_voltage(temp),
        .meas_valid(meas_valid), .meas_freq(meas_freq));
    rf_ramp_frequency_calibration i_dut (.clk(clk), .srst(srst),
        .boot_start(boot_start), .frame_done(frame_done),
        .measure_start(measure_start),
        .step_size(step_size), .probe_offset(probe_offset),
        .tx_shift(tx_shift), .chirp_code(chirp_code), .adc_done(adc_done),
        .temp_proportional_voltage(temp), .meas_valid(meas_valid),
        .meas_freq(meas_freq), .chip_enable(chip_enable),
        .tx_enable(tx_enable), .divider_enable(divider_enable),
        .adc_request(adc_request), .meas_request(meas_request),
        .dac_code(dac_code), .low_code(low_code), .high_code(high_code),
        .cal_busy(cal_busy), .cal_done(cal_done),
        .recal_event(recal_event), .radar_active(radar_active));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // log every measured code; count recalibrations; cut hangs short
    always @(posedge clk) begin
        cycles++;
        if (meas_request) seq.push_back(dac_code);
        if (recal_event) rc++;
        if (cycles == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    task conclude();
        $display("errors %0d, comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task check(input logic [63:0] seen, input logic [63:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
            error_cnt++;
        end
    endtask
    task strobe(input int k);
        @(posedge clk);
        boot_start <= (k == 0);
        measure_start <= (k == 1);
        frame_done <= (k == 2);
        @(posedge clk);
        {boot_start, measure_start, frame_done} <= 3'b000;
    endtask
    // done once no request or answer has moved for 30 cycles
    task automatic wait_quiet();
        int q;
        int t;
        q = 0;
        for (t = 0; t < 6000 && q < 30; t++) begin
            @(posedge clk);
            q = (meas_request || meas_valid) ? 0 : q + 1;
        end
        check(q >= 30, 1);
        @(negedge clk);
    endtask
    task automatic frame();
        int t;
        strobe(1);
        for (t = 0; t < 50 && !radar_active; t++) @(posedge clk);
        seq.delete();
        rc = 0;
        strobe(2);
        wait_quiet();
    endtask
    function automatic logic has(input logic [`DAC_W-1:0] c);
        foreach (seq[i]) if (seq[i] === c) return 1'b1;
        return 1'b0;
    endfunction
    initial begin
        {srst, boot_start, frame_done, measure_start} <= 4'b1000;
        {step_size, probe_offset} <= {12'h010, 12'h010};
        {tx_shift, chirp_code} <= {12'hFFB, 12'h900};
        {f_base, f_slope} = {32'h016CFE48, 32'h00000064};
        repeat (20) @(posedge clk);
        @(negedge clk);
        check({chip_enable, tx_enable, divider_enable, adc_request,
            meas_request, cal_busy, cal_done, recal_event, radar_active}, 0);
        check({dac_code, low_code, high_code}, 36'h800800800);
        @(posedge clk);
        srst <= 1'b0;
        seq.delete();
        strobe(0);
        wait_quiet();
        check(seq[0], 12'h800);
        check(seq[1], 12'h7F0);
        check(seq[60], 12'h440);
        check(seq[61], 12'h450);
        check(seq[180], 12'hBC0);
        check({seq[181], seq[182], seq[184]}, 36'h440430BB0);
        check(rc, 1);
        check({cal_done, tx_enable}, 2'b10);
        check({low_code, high_code}, 24'h418BE8);
        check(dac_code, 12'h800);
        strobe(1);
        repeat (3) @(negedge clk);
        check({radar_active, tx_enable, divider_enable}, 3'b110);
        check(dac_code, 12'h8FB);
        frame();
        check(seq.size(), 2);
        check({seq[0], seq[1]}, 24'h418BE8);
        check(rc, 0);
        {f_base, f_slope} = {32'h016C97F0, 32'h0000007D};
        frame();
        check(seq[2] > 12'h800, 1);
        check(has(12'hBD8), 1);
        check({low_code, high_code}, 24'h418A58);
        check({dac_code, rc[7:0]}, 20'h73801);
        {f_base, f_slope} = {32'h016CDF08, 32'h00000064};
        frame();
        check(seq[1], 12'h428);
        check({low_code, high_code}, 24'h468C38);
        check({dac_code, rc[7:0]}, 20'h85001);
        conclude();
    end
endmodule // tb

// *** verification/xcvr_model.sv ***
// behavioural transceiver: tuning input, divider counter, temp sensor
`include "rf_cal_consts.vh"
module xcvr_model (
    input wire clk,
    input wire srst,
    input wire chip_enable,
    input wire tx_enable,
    input wire divider_enable,
    input wire adc_request,
    input wire meas_request,
    input wire [`DAC_W-1:0] dac_code,
    input wire [`FREQ_W-1:0] f_base,
    input wire [`FREQ_W-1:0] f_slope,
    output logic adc_done,
    output logic [`DAC_W-1:0] temp_proportional_voltage,
    output logic meas_valid,
    output logic [`FREQ_W-1:0] meas_freq
);
    timeunit 1ns;
    timeprecision 1ps;
    parameter logic [`DAC_W-1:0] TEMP_CODE = 12'h800;
    int wait_cnt;
    int adc_cnt;
    int n;
    logic [`FREQ_W-1:0] f_now;
    // monotonic tuning law; transmit load pulls the oscillator up
    assign f_now = f_base + dac_code * f_slope
        + (tx_enable ? 32'h00000BB8 : 32'h0);
    // answers alternate fast and slow; no divider means no answer
    always @(posedge clk) begin
        adc_done <= 1'b0;
        meas_valid <= 1'b0;
        meas_freq <= ~meas_freq;
        temp_proportional_voltage <= ~temp_proportional_voltage;
        if (srst) begin
            wait_cnt <= 0;
            adc_cnt <= 0;
            n <= 0;
            meas_freq <= 32'h5A5A5A5A;
            temp_proportional_voltage <= 12'h5A5;
        end else begin
            if (adc_request && chip_enable)
                adc_cnt <= 3;
            else if (adc_cnt != 0)
                adc_cnt <= adc_cnt - 1;
            if (adc_cnt == 1) begin
                adc_done <= 1'b1;
                temp_proportional_voltage <= TEMP_CODE;
            end
            if (meas_request && divider_enable) begin
                wait_cnt <= n[0] ? 7 : 1;
                n <= n + 1;
            end else if (wait_cnt != 0)
                wait_cnt <= wait_cnt - 1;
            if (wait_cnt == 1) begin
                meas_valid <= 1'b1;
                meas_freq <= f_now;
            end
        end
    end
endmodule // xcvr_model
